//--- core/atrb_core.sv
/*
 * Analog test register group: aux pin routing, two test DAC codes, a live ADC view and
 * four production-test registers, reached by the register port of the host interface.
 * Assumes the host interface decoder delivers one-cycle read/write strobes on ref_clk_in
 * and that the ADC samples arrive asynchronously, so they are synchronised here.
 */
// Functional notes
// R1: bits 5..0 of the first test DAC register are a read/write code driving the first DAC.
// R2: the first DAC output goes to the first aux pin when the first aux select holds 0001.
// R3: bits 5..0 of the second test DAC register are a read/write code driving the second DAC.
// R4: the second DAC output goes to the second aux pin when the second aux select holds 0001.
// R5: bits 7 and 6 of both test DAC registers read as zero and ignore writes.
// R6: bits 7..4 of the ADC view register show the current in-phase ADC sample.
// R7: bits 3..0 of the ADC view register show the current quadrature ADC sample.
// R8: the production-test registers reset to FFh, 00h, 03h and 00h at 3Ch to 3Fh.
// R9: an aux select of 0000 tristates the pin and 0001 routes the matching DAC to it.
// R10: writes to the ADC view register have no effect.
`timescale 1ns/1ps
`include "atrb_map.svh"

module atrb_core (
	input  wire logic                            ref_clk_in,
	input  wire logic                            reset_in,
	input  wire atrb_pkg::atrb_req_type          req_in,
	input  wire atrb_pkg::atrb_adc_type          adc_in,
	output logic      [`ATRB_DATA_W-1:0]         rdata_out,
	output logic                                 rvalid_out,
	output logic      [`ATRB_DAC_W-1:0]          first_dac_code_out,
	output logic      [`ATRB_DAC_W-1:0]          second_dac_code_out,
	output atrb_pkg::atrb_aux_mode_type          first_aux_pin_mode_out,
	output atrb_pkg::atrb_aux_mode_type          second_aux_pin_mode_out,
	output logic      [`ATRB_SEL_W-1:0]          first_aux_select_out,
	output logic      [`ATRB_SEL_W-1:0]          second_aux_select_out
);
	import atrb_pkg::*;

	// aux select value to pin mode; used for both pins
	function automatic atrb_aux_mode_type aux_mode(input logic [`ATRB_SEL_W-1:0] sel);
		atrb_aux_mode_type m;
		case (sel)
			`ATRB_SEL_TRISTATE: m = ATRB_AUX_TRISTATE; // R9
			`ATRB_SEL_DAC:      m = ATRB_AUX_DAC;      // R9
			default:            m = ATRB_AUX_OTHER;
		endcase
		return m;
	endfunction

	function automatic logic [`ATRB_DATA_W-1:0] ptest_reset(input int idx);
		logic [`ATRB_DATA_W-1:0] v;
		case (idx)
			0:       v = `ATRB_RST_PTEST_A;
			1:       v = `ATRB_RST_PTEST_B;
			2:       v = `ATRB_RST_PTEST_C;
			default: v = `ATRB_RST_PTEST_D;
		endcase
		return v;
	endfunction

	// one-hot register decode, shared by the write path and the read path
	function automatic logic [`ATRB_HIT_W-1:0] reg_hit(input logic [`ATRB_ADDR_W-1:0] addr);
		logic [`ATRB_HIT_W-1:0] h;
		h = `ATRB_HIT_NONE;
		case (addr)
			`ATRB_OFS_ROUTING: h[`ATRB_HIT_ROUTING] = 1'h1;
			`ATRB_OFS_DAC1:    h[`ATRB_HIT_DAC1]    = 1'h1;
			`ATRB_OFS_DAC2:    h[`ATRB_HIT_DAC2]    = 1'h1;
			`ATRB_OFS_ADC:     h[`ATRB_HIT_ADC]     = 1'h1;
			`ATRB_OFS_PTEST_A,
			`ATRB_OFS_PTEST_B,
			`ATRB_OFS_PTEST_C,
			`ATRB_OFS_PTEST_D: h[`ATRB_HIT_PTEST]   = 1'h1;
			default:           h = `ATRB_HIT_NONE;
		endcase
		return h;
	endfunction

	atrb_routing_type              routing_q,   routing_d;
	logic [`ATRB_DAC_W-1:0]        dac1_q,      dac1_d;
	logic [`ATRB_DAC_W-1:0]        dac2_q,      dac2_d;
	atrb_aux_mode_type             mode1_q,     mode1_d;
	atrb_aux_mode_type             mode2_q,     mode2_d;
	logic [`ATRB_DATA_W-1:0]       ptest_q [`ATRB_PTEST_CNT];
	logic [`ATRB_DATA_W-1:0]       ptest_d [`ATRB_PTEST_CNT];
	atrb_adc_type                  adc_meta_q;
	atrb_adc_type                  adc_sync_q;
	logic [`ATRB_DATA_W-1:0]       rdata_q,     rdata_d;
	logic                          rvalid_q,    rvalid_d;
	logic [`ATRB_HIT_W-1:0]        wr_hit;
	logic [`ATRB_HIT_W-1:0]        rd_hit;
	logic [`ATRB_PTEST_IDX_W-1:0]  ptest_idx;

	assign wr_hit    = req_in.wr_en ? reg_hit(req_in.addr) : `ATRB_HIT_NONE;
	assign rd_hit    = req_in.rd_en ? reg_hit(req_in.addr) : `ATRB_HIT_NONE;
	assign ptest_idx = req_in.addr[`ATRB_PTEST_IDX_W-1:0];

	// aux pin routing register
	always_comb begin
		routing_d = routing_q;
		if (wr_hit[`ATRB_HIT_ROUTING]) begin
			routing_d = req_in.wdata;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			routing_q <= `ATRB_RST_ROUTING;
		end else begin
			routing_q <= routing_d;
		end
	end

	// pin modes decoded from the next routing value, so they change with the register
	always_comb begin
		mode1_d = aux_mode(routing_d.first_aux_select);  // R2 R9
		mode2_d = aux_mode(routing_d.second_aux_select); // R4 R9
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			mode1_q <= ATRB_AUX_TRISTATE; // R9
			mode2_q <= ATRB_AUX_TRISTATE; // R9
		end else begin
			mode1_q <= mode1_d;
			mode2_q <= mode2_d;
		end
	end

	// test dac codes; the upper two bits of a write are dropped
	always_comb begin
		dac1_d = dac1_q;
		dac2_d = dac2_q;
		if (wr_hit[`ATRB_HIT_DAC1]) begin
			dac1_d = req_in.wdata[`ATRB_DAC_W-1:0]; // R1 R5
		end
		if (wr_hit[`ATRB_HIT_DAC2]) begin
			dac2_d = req_in.wdata[`ATRB_DAC_W-1:0]; // R3 R5
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			dac1_q <= `ATRB_RST_DAC;
			dac2_q <= `ATRB_RST_DAC;
		end else begin
			dac1_q <= dac1_d;
			dac2_q <= dac2_d;
		end
	end

	// production-test registers, plain read/write storage
	always_comb begin
		for (int i = 0; i < `ATRB_PTEST_CNT; i++) begin
			ptest_d[i] = ptest_q[i];
		end
		if (wr_hit[`ATRB_HIT_PTEST]) begin
			ptest_d[ptest_idx] = req_in.wdata;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `ATRB_PTEST_CNT; g++) begin : g_ptest
			always_ff @(posedge ref_clk_in) begin
				if (reset_in) begin
					ptest_q[g] <= ptest_reset(g); // R8
				end else begin
					ptest_q[g] <= ptest_d[g];
				end
			end
		end
	endgenerate

	// read mux, answered one cycle after the strobe; unmapped offsets read zero
	always_comb begin
		rdata_d  = rdata_q;
		rvalid_d = req_in.rd_en;
		if (req_in.rd_en) begin
			rdata_d = `ATRB_ZERO8;
		end
		if (rd_hit[`ATRB_HIT_ROUTING]) begin
			rdata_d = routing_q;
		end
		if (rd_hit[`ATRB_HIT_DAC1]) begin
			rdata_d = {`ATRB_ZERO2, dac1_q}; // R1 R5
		end
		if (rd_hit[`ATRB_HIT_DAC2]) begin
			rdata_d = {`ATRB_ZERO2, dac2_q}; // R3 R5
		end
		if (rd_hit[`ATRB_HIT_ADC]) begin
			rdata_d = {adc_sync_q.i_chan, adc_sync_q.q_chan}; // R6 R7
		end
		if (rd_hit[`ATRB_HIT_PTEST]) begin
			rdata_d = ptest_q[ptest_idx];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rdata_q  <= `ATRB_ZERO8;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// adc samples come from the analog side, two flops before use
	// the view holds no state of its own, so a write to it has nothing to load
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			adc_meta_q <= '0;
			adc_sync_q <= '0;
		end else begin
			adc_meta_q <= adc_in;
			adc_sync_q <= adc_meta_q; // R6 R7 R10
		end
	end

	assign rdata_out               = rdata_q;
	assign rvalid_out              = rvalid_q;
	assign first_dac_code_out      = dac1_q; // R1
	assign second_dac_code_out     = dac2_q; // R3
	assign first_aux_select_out    = routing_q.first_aux_select;
	assign second_aux_select_out   = routing_q.second_aux_select;
	assign first_aux_pin_mode_out  = mode1_q; // R2 R9
	assign second_aux_pin_mode_out = mode2_q; // R4 R9

endmodule

//--- core/atrb_map.svh
/*
 * Register offsets, field positions, reset values and codes of the analog test register group.
 * Assumes it is included by its bare name from the package and the core module.
 */
`ifndef ATRB_MAP_SVH
`define ATRB_MAP_SVH

`define ATRB_ADDR_W          6
`define ATRB_DATA_W          8
`define ATRB_OFS_ROUTING     6'h38
`define ATRB_OFS_DAC1        6'h39
`define ATRB_OFS_DAC2        6'h3A
`define ATRB_OFS_ADC         6'h3B
`define ATRB_OFS_PTEST_A     6'h3C
`define ATRB_OFS_PTEST_B     6'h3D
`define ATRB_OFS_PTEST_C     6'h3E
`define ATRB_OFS_PTEST_D     6'h3F
`define ATRB_PTEST_BASE      6'h3C
`define ATRB_PTEST_CNT       4
`define ATRB_PTEST_IDX_W     2
`define ATRB_RST_ROUTING     8'h00
`define ATRB_RST_DAC         6'h00
`define ATRB_RST_PTEST_A     8'hFF
`define ATRB_RST_PTEST_B     8'h00
`define ATRB_RST_PTEST_C     8'h03
`define ATRB_RST_PTEST_D     8'h00
`define ATRB_DAC_W           6
`define ATRB_ADC_W           4
`define ATRB_SEL_W           4
`define ATRB_SEL_TRISTATE    4'h0
`define ATRB_SEL_DAC         4'h1
`define ATRB_ZERO2           2'h0
`define ATRB_ZERO8           8'h00

`define ATRB_HIT_W           5
`define ATRB_HIT_ROUTING     0
`define ATRB_HIT_DAC1        1
`define ATRB_HIT_DAC2        2
`define ATRB_HIT_ADC         3
`define ATRB_HIT_PTEST       4
`define ATRB_HIT_NONE        5'h00

`endif

//--- core/atrb_pkg.sv
/*
 * Types of the analog test register group.
 * Assumes atrb_map.svh is on the include path.
 */
`include "atrb_map.svh"

package atrb_pkg;

	typedef struct packed {
		logic                      wr_en;
		logic                      rd_en;
		logic [`ATRB_ADDR_W-1:0]   addr;
		logic [`ATRB_DATA_W-1:0]   wdata;
	} atrb_req_type;

	typedef struct packed {
		logic [`ATRB_ADC_W-1:0] i_chan;
		logic [`ATRB_ADC_W-1:0] q_chan;
	} atrb_adc_type;

	typedef struct packed {
		logic [`ATRB_SEL_W-1:0] first_aux_select;
		logic [`ATRB_SEL_W-1:0] second_aux_select;
	} atrb_routing_type;

	typedef enum logic [1:0] {
		ATRB_AUX_TRISTATE = 2'b00,
		ATRB_AUX_DAC      = 2'b01,
		ATRB_AUX_OTHER    = 2'b10
	} atrb_aux_mode_type;

endpackage

//--- verification/atrb_core_checker.sv
/* Assertions on the ports of atrb_core.
   Assumes it is bound to atrb_core from the bench top. */
`timescale 1ns/1ps
module atrb_checker (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire atrb_pkg::atrb_req_type req_in,
	input wire atrb_pkg::atrb_adc_type adc_in,
	input wire logic [7:0] rdata_out,
	input wire logic [5:0] first_dac_code_out,
	input wire logic [5:0] second_dac_code_out,
	input wire atrb_pkg::atrb_aux_mode_type first_aux_pin_mode_out,
	input wire atrb_pkg::atrb_aux_mode_type second_aux_pin_mode_out,
	input wire logic [3:0] first_aux_select_out,
	input wire logic [3:0] second_aux_select_out
);
	import atrb_pkg::*;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	wire wr1 = req_in.wr_en && req_in.addr == 6'h39;
	wire wr2 = req_in.wr_en && req_in.addr == 6'h3A;
	wire rd_dac = req_in.rd_en && (req_in.addr == 6'h39 || req_in.addr == 6'h3A);
	wire rd_adc = req_in.rd_en && req_in.addr == 6'h3B;
	// adc input held across both synchroniser stages, then read
	sequence adc_held;
		$stable(adc_in)[*3] ##0 rd_adc;
	endsequence
	AST_DAC1: assert property (wr1 |=> first_dac_code_out == $past(req_in.wdata[5:0]))
		else $error("first dac code not written");
	AST_DAC2: assert property (wr2 |=> second_dac_code_out == $past(req_in.wdata[5:0]))
		else $error("second dac code not written");
	AST_RSVD: assert property (rd_dac |=> rdata_out[7:6] == 2'h0)
		else $error("reserved dac bits read nonzero");
	AST_ADC_I: assert property (adc_held |=> rdata_out[7:4] == $past(adc_in.i_chan))
		else $error("in-phase view wrong");
	AST_ADC_Q: assert property (adc_held |=> rdata_out[3:0] == $past(adc_in.q_chan))
		else $error("quadrature view wrong");
	AST_SEL1: assert property (first_aux_select_out == 4'h1 |->
		first_aux_pin_mode_out == ATRB_AUX_DAC)
		else $error("first pin not routed to dac");
	AST_SEL2: assert property (second_aux_select_out == 4'h1 |->
		second_aux_pin_mode_out == ATRB_AUX_DAC)
		else $error("second pin not routed to dac");
	AST_TRI: assert property (first_aux_select_out == 4'h0 |->
		first_aux_pin_mode_out == ATRB_AUX_TRISTATE)
		else $error("first pin not tristate");
	AST_TRI2: assert property (second_aux_select_out == 4'h0 |->
		second_aux_pin_mode_out == ATRB_AUX_TRISTATE)
		else $error("second pin not tristate");
endmodule

//--- verification/atrb_tb_top.sv
/* Self-checking bench for atrb_core.
   Assumes the package and the checker are compiled first. */
`timescale 1ns/1ps
`define CHK(w, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", w, e, s); end end
module atrb_tb_top;
	import atrb_pkg::*;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	atrb_req_type req_in = '0;
	atrb_adc_type adc_in = '0;
	logic [7:0] rdata_out;
	logic rvalid_out;
	logic [5:0] first_dac_code_out;
	logic [5:0] second_dac_code_out;
	atrb_aux_mode_type first_aux_pin_mode_out;
	atrb_aux_mode_type second_aux_pin_mode_out;
	logic [3:0] first_aux_select_out;
	logic [3:0] second_aux_select_out;
	int err_total = 0;
	int comparisons = 0;
	atrb_core atrb_core_i (.ref_clk_in, .reset_in, .req_in, .adc_in, .rdata_out, .rvalid_out,
		.first_dac_code_out, .second_dac_code_out, .first_aux_pin_mode_out,
		.second_aux_pin_mode_out, .first_aux_select_out, .second_aux_select_out);
	initial forever #2 ref_clk_in = ~ref_clk_in;
	function automatic atrb_aux_mode_type mode_of(input logic [3:0] s);
		return s == 4'h0 ? ATRB_AUX_TRISTATE : s == 4'h1 ? ATRB_AUX_DAC : ATRB_AUX_OTHER;
	endfunction
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		req_in = '{1'b1, 1'b0, a, d};
		@(negedge ref_clk_in);
		req_in.wr_en = 1'b0;
	endtask
	task rd(input logic [5:0] a, input logic [7:0] e);
		@(negedge ref_clk_in);
		req_in = '{1'b0, 1'b1, a, 8'h00};
		@(negedge ref_clk_in);
		req_in.rd_en = 1'b0;
		`CHK("rvalid", 1'b1, rvalid_out)
		`CHK("rdata", e, rdata_out)
	endtask
	task end_of_test;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#4000;
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (8) @(negedge ref_clk_in);
		reset_in = 1'b0;
		`CHK("mode1", ATRB_AUX_TRISTATE, first_aux_pin_mode_out)
		rd(6'h3C, 8'hFF);
		rd(6'h3D, 8'h00);
		rd(6'h3E, 8'h03);
		rd(6'h3F, 8'h00);
		wr(6'h39, 8'hFF);
		`CHK("dac1", 6'h3F, first_dac_code_out)
		wr(6'h3A, 8'hC5);
		rd(6'h39, 8'h3F);
		rd(6'h3A, 8'h05);
		`CHK("dac2", 6'h05, second_dac_code_out)
		adc_in = 8'hA5;
		wr(6'h3B, 8'h00);
		repeat (2) @(negedge ref_clk_in);
		rd(6'h3B, 8'hA5);
		adc_in = 8'h3C;
		repeat (2) @(negedge ref_clk_in);
		rd(6'h3B, 8'h3C);
		for (int i = 0; i < 16; i++) begin
			wr(6'h38, {4'(i), 4'(15 - i)});
			`CHK("mode1", mode_of(4'(i)), first_aux_pin_mode_out)
			`CHK("mode2", mode_of(4'(15 - i)), second_aux_pin_mode_out)
			`CHK("sel1", 4'(i), first_aux_select_out)
			`CHK("sel2", 4'(15 - i), second_aux_select_out)
		end
		rd(6'h38, 8'hF0);
		wr(6'h3C, 8'h5A);
		rd(6'h3C, 8'h5A);
		@(negedge ref_clk_in);
		reset_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		reset_in = 1'b0;
		rd(6'h3C, 8'hFF);
		`CHK("dac1 reset", 6'h00, first_dac_code_out)
		`CHK("mode1 reset", ATRB_AUX_TRISTATE, first_aux_pin_mode_out)
		end_of_test();
	end
endmodule
bind atrb_core atrb_checker atrb_checker_i (.ref_clk_in, .reset_in, .req_in, .adc_in,
	.rdata_out, .first_dac_code_out, .second_dac_code_out, .first_aux_pin_mode_out,
	.second_aux_pin_mode_out, .first_aux_select_out, .second_aux_select_out);
